//--- verilog/fwsr_regs.svh
`ifndef FWSR_REGS_SVH
`define FWSR_REGS_SVH
// Status bit positions on the data lines.
`define FWSR_BIT_POLL     7
`define FWSR_BIT_ACT      6
`define FWSR_BIT_TMO      5
`define FWSR_BIT_WIN      3
`define FWSR_BIT_SECT     2
// Reset command word and bus timing in cycles of the 50 ns clock.
`define FWSR_RESET_CMD    16'h00f0
`define FWSR_RD_CYC       3'h3
`define FWSR_WR_CYC       3'h2
`define FWSR_CNT_ZERO     3'h0
`endif

//--- verilog/fwsr_pkg.sv
package fwsr_pkg;
   // Verdict of one status check.
   typedef enum logic [1:0] {
      FWSR_DONE    = 2'h0,
      FWSR_FAILED  = 2'h1,
      FWSR_BUSY    = 2'h2
   } fwsr_result_t;
endpackage

//--- verilog/fwsr_bus_cycle.sv
`include "fwsr_regs.svh"
// One asynchronous read or write cycle on the flash pins.
module fwsr_bus_cycle
   import fwsr_pkg::*;
#(
   parameter int DW = 16
) (
   input  wire logic          clk,      // Clock.
   input  wire logic          rst,      // Sync reset.
   input  wire logic          start,    // Start one cycle.
   input  wire logic          isWrite,  // Write when high.
   input  wire logic [DW-1:0] wrData,   // Data to write.
   input  wire logic [DW-1:0] dataIn,   // Data lines in.
   output logic               chipSelN, // Chip select, low active.
   output logic               outEnN,   // Output strobe, low active.
   output logic               wrEnN,    // Write strobe, low active.
   output logic [DW-1:0]      dataOut,  // Data lines out.
   output logic               dataOe,   // High while we drive.
   output logic               done,     // One-cycle end pulse.
   output logic [DW-1:0]      rdData    // Captured read word.
);
   logic [2:0] cnt_reg;
   logic       busy_reg;

   // The status bits sit in the low byte, so a narrower bus is refused.
   if (DW < 8) begin : g_bad_dw
      $error("fwsr_bus_cycle: DW below 8");
   end

   ////////////////////////////////////////////////////////////////////
   // Strobes stay asserted for a fixed count; data is sampled at the
   // last cycle so access time has elapsed.
   always_ff @(posedge clk) begin
      done <= 1'b0;
      if (rst) begin
         busy_reg <= 1'b0;
         cnt_reg  <= `FWSR_CNT_ZERO;
         chipSelN <= 1'b1;
         outEnN   <= 1'b1;
         wrEnN    <= 1'b1;
         dataOe   <= 1'b0;
         dataOut  <= '0;
         rdData   <= '0;
      end else if (!busy_reg && start) begin
         busy_reg <= 1'b1;
         cnt_reg  <= isWrite ? `FWSR_WR_CYC : `FWSR_RD_CYC;
         chipSelN <= 1'b0;
         outEnN   <= isWrite;
         wrEnN    <= !isWrite;
         dataOe   <= isWrite;
         dataOut  <= wrData;
      end else if (busy_reg) begin
         if (cnt_reg == `FWSR_CNT_ZERO) begin
            // Deasserting both strobes ends the cycle; the device advances
            // its toggle bits at the start of the next read.
            busy_reg <= 1'b0;
            chipSelN <= 1'b1;
            outEnN   <= 1'b1;
            wrEnN    <= 1'b1;
            dataOe   <= 1'b0;
            done     <= 1'b1;
            if (!outEnN) rdData <= dataIn;
         end else begin
            cnt_reg <= cnt_reg - 3'h1;
         end
      end
   end
endmodule // fwsr_bus_cycle

//--- verilog/fwsr_status_poller.sv
// Contract
// - Host may pace reads with output strobe or chip select.
// - Start with two back-to-back reads; unchanged toggle means done.
// - Toggling with timeout high: recheck; still toggling means fail, reset.
// - Resuming after a pause restarts from the first double read.
// - After timeout failure host must write the reset command.
// - Monitor window bit unless added commands under 50 us apart.
// - Check window bit before and after each extra sector command.
// - Status reads must address the busy bank.
// - Poll and sector bits need a valid address.
// - Combine both toggle bits to find mode and erasing sectors.
`include "fwsr_regs.svh"
module fwsr_status_poller
   import fwsr_pkg::*;
#(
   parameter int DW = 16,
   parameter int AW = 22
) (
   input  wire logic          clk,          // Clock, 20 MHz.
   input  wire logic          rst,          // Sync reset, high.
   input  wire logic          checkReq,     // Pulse: run a status check.
   input  wire logic          windowReq,    // Pulse: sample window bit.
   input  wire logic [AW-1:0] statusAddr,   // Address in busy sector.
   input  wire logic [DW-1:0] data_lines_i, // Data lines in.
   input  wire logic          operation_done_pin_n, // Ready pin level.
   output logic [AW-1:0]      flashAddr,    // Address lines.
   output logic               chipSelN,     // Chip select, low.
   output logic               outEnN,       // Output strobe, low.
   output logic               wrEnN,        // Write strobe, low.
   output logic [DW-1:0]      data_lines_o, // Data lines out.
   output logic               data_lines_oe,// Drive enable.
   output logic               busy,         // Check or window read in progress.
   output logic               resultValid,  // Pulse: verdict ready.
   output fwsr_result_t       result,       // Verdict.
   output logic               eraseActive,  // Sector toggle seen.
   output logic               suspended,    // Sector toggles, not activity.
   output logic               windowValid,  // Pulse: window bit ready.
   output logic               windowClosed, // Window bit was 1.
   output logic               readyLevel    // Registered ready pin.
);
   // One state per bus cycle of the check, so every read and the reset
   // write can be told apart in a waveform; codes are one-hot.
   typedef enum logic [6:0] {
      S_IDLE  = 7'b0000001,
      S_RD1   = 7'b0000010,
      S_RD2   = 7'b0000100,
      S_RD3   = 7'b0001000,
      S_RST   = 7'b0010000,
      S_WIN   = 7'b0100000,
      S_END   = 7'b1000000
   } fwsr_state_t;

   // Handshake with the pin sequencer and the stored first word.
   fwsr_state_t state_reg;
   logic          start;
   logic          isWrite;
   logic          cycDone;
   logic [DW-1:0] rdData;
   logic [DW-1:0] first_reg;
   logic          issued_reg;
   logic          actDiff;
   logic          sectDiff;

   // The status bits sit in the low byte, so a narrower bus cannot be
   // polled at all.
   if (AW < 1 || DW < 8) begin : g_bad_par
      $error("fwsr_status_poller: AW below 1 or DW below 8");
   end

   ////////////////////////////////////////////////////////////////////
   // Pin sequencer; chip select and the active strobe rise together at each cycle end.
   // Only the reset command is ever written, so the write data is a
   // constant sized to the bus.
   fwsr_bus_cycle #(.DW(DW)) u_cycle (
      .clk      (clk),
      .rst      (rst),
      .start    (start),
      .isWrite  (isWrite),
      .wrData   (DW'(`FWSR_RESET_CMD)),
      .dataIn   (data_lines_i),
      .chipSelN (chipSelN),
      .outEnN   (outEnN),
      .wrEnN    (wrEnN),
      .dataOut  (data_lines_o),
      .dataOe   (data_lines_oe),
      .done     (cycDone),
      .rdData   (rdData)
   );

   // Launch a cycle once per state; write only for the reset command.
   // The issued flag stops a second launch while the cycle is open.
   assign start   = !issued_reg && (state_reg != S_IDLE)
                    && (state_reg != S_END);
   assign isWrite = (state_reg == S_RST);
   // Compare the fresh word against the stored one.
   assign actDiff  = rdData[`FWSR_BIT_ACT]  ^ first_reg[`FWSR_BIT_ACT];
   assign sectDiff = rdData[`FWSR_BIT_SECT] ^ first_reg[`FWSR_BIT_SECT];

   ////////////////////////////////////////////////////////////////////
   // Address is held on the busy bank for every status read.
   always_ff @(posedge clk) begin
      if (rst) begin
         flashAddr <= '0;
      end else if (state_reg == S_IDLE && (checkReq || windowReq)) begin
         flashAddr <= statusAddr;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Ready pin is sampled as an ordinary synchronous input. It is only
   // reported, not used to end a check, since a suspended erase shows
   // ready while its status is still meaningful.
   always_ff @(posedge clk) begin
      if (rst) readyLevel <= 1'b0;
      else     readyLevel <= operation_done_pin_n;
   end

   ////////////////////////////////////////////////////////////////////
   // Toggle check. Every check starts with a fresh double read, so a
   // caller that paused simply issues a new request. A limitation: a
   // request that arrives while busy is dropped without notice.
   always_ff @(posedge clk) begin
      resultValid <= 1'b0;
      windowValid <= 1'b0;
      if (rst) begin
         // Verdict outputs return to their idle values.
         state_reg    <= S_IDLE;
         issued_reg   <= 1'b0;
         first_reg    <= '0;
         busy         <= 1'b0;
         result       <= FWSR_DONE;
         eraseActive  <= 1'b0;
         suspended    <= 1'b0;
         windowClosed <= 1'b0;
      end else begin
         if (start) issued_reg <= 1'b1;
         if (cycDone) issued_reg <= 1'b0;
         unique case (state_reg)
            // A check request wins over a window request in one cycle.
            S_IDLE: begin
               if (checkReq) begin
                  state_reg <= S_RD1;
                  busy      <= 1'b1;
               end else if (windowReq) begin
                  state_reg <= S_WIN;
                  busy      <= 1'b1;
               end
            end
            // The first word of the double read is kept for comparison.
            S_RD1: begin
               if (cycDone) begin
                  first_reg <= rdData;
                  state_reg <= S_RD2;
               end
            end
            // The second word decides; its timeout bit picks the recheck.
            // It is stored again so the recheck compares neighbours.
            S_RD2: begin
               if (cycDone) begin
                  first_reg   <= rdData;
                  eraseActive <= sectDiff;
                  suspended   <= sectDiff && !actDiff;
                  if (!actDiff) begin
                     result    <= FWSR_DONE;
                     state_reg <= S_END;
                  end else if (rdData[`FWSR_BIT_TMO]) begin
                     state_reg <= S_RD3;
                  end else begin
                     result    <= FWSR_BUSY;
                     state_reg <= S_END;
                  end
               end
            end
            // The toggle may stop just as the timeout bit rises, so a
            // quiet third read still counts as success.
            S_RD3: begin
               if (cycDone) begin
                  if (actDiff) begin
                     result    <= FWSR_FAILED;
                     state_reg <= S_RST;
                  end else begin
                     result    <= FWSR_DONE;
                     state_reg <= S_END;
                  end
               end
            end
            // The reset write returns the bank to array reads; the
            // verdict waits until the write strobe has risen.
            S_RST: begin
               if (cycDone) state_reg <= S_END;
            end
            // One plain read; the window verdict needs no comparison.
            S_WIN: begin
               if (cycDone) begin
                  windowClosed <= rdData[`FWSR_BIT_WIN];
                  windowValid  <= 1'b1;
                  busy         <= 1'b0;
                  state_reg    <= S_IDLE;
               end
            end
            // One cycle for the verdict pulse; busy falls with it so a
            // new request may follow at the next edge.
            S_END: begin
               resultValid <= 1'b1;
               busy        <= 1'b0;
               state_reg   <= S_IDLE;
            end
            default: state_reg <= S_IDLE;
         endcase
      end
   end
endmodule // fwsr_status_poller

//--- dv/fwsr_poller_monitor.sv
`include "fwsr_regs.svh"
module fwsr_poller_monitor
   import fwsr_pkg::*;
#(
   parameter int DW = 16,
   parameter int AW = 22
) (
   input wire logic          clk,           // Clock.
   input wire logic          rst,           // Reset.
   input wire logic          checkReq,      // Check.
   input wire logic          windowReq,     // Window.
   input wire logic [AW-1:0] flashAddr,     // Address.
   input wire logic          chipSelN,      // Select.
   input wire logic          outEnN,        // Read.
   input wire logic          wrEnN,         // Write.
   input wire logic [DW-1:0] data_lines_o,  // Out.
   input wire logic          data_lines_oe, // Drive.
   input wire logic          busy,          // Busy.
   input wire logic          resultValid,   // Verdict.
   input wire fwsr_result_t  result,        // Code.
   input wire logic          windowValid    // Window.
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   logic [2:0] rdCnt;
   logic       wrSeen;
   ///////////////////////////////////////////////////////////////////////////
   // Reads and writes of the current check, so a verdict can be judged.
   always_ff @(posedge clk) begin
      if (rst || (checkReq && !busy)) begin
         rdCnt  <= 3'h0;
         wrSeen <= 1'b0;
      end else begin
         if ($fell(outEnN) && rdCnt != 3'h7) rdCnt <= rdCnt + 3'h1;
         if (!wrEnN) wrSeen <= 1'b1;
      end
   end
   sequence s_rd_start;
      $fell(outEnN) ##0 !chipSelN;
   endsequence
   sequence s_fail;
      resultValid && result == FWSR_FAILED;
   endsequence
   ///////////////////////////////////////////////////////////////////////////
   a_read_select: assert property ($fell(outEnN) |-> !chipSelN && wrEnN)
      else $error("read strobe without select");
   a_read_length: assert property ($fell(outEnN) |-> !outEnN[*4])
      else $error("read strobe too short");
   a_addr_hold: assert property (s_rd_start |=> $stable(flashAddr)[*3])
      else $error("address moved in a read");
   a_no_clash: assert property (!outEnN |-> !data_lines_oe)
      else $error("host drives during a read");
   a_two_reads: assert property (resultValid |-> rdCnt >= 3'h2)
      else $error("verdict before two reads");
   a_fail_reads: assert property (s_fail |-> rdCnt >= 3'h3)
      else $error("failure without a recheck");
   a_fail_reset: assert property (s_fail |-> wrSeen)
      else $error("failure without reset write");
   a_reset_word: assert property (!wrEnN |-> data_lines_oe &&
      data_lines_o == `FWSR_RESET_CMD) else $error("bad reset word");
   a_window_ans: assert property (windowReq && !checkReq && !busy
      |-> ##[2:12] windowValid) else $error("window read lost");
endmodule // fwsr_poller_monitor

bind fwsr_status_poller fwsr_poller_monitor #(.DW(DW), .AW(AW)) i_mon (
   .clk(clk), .rst(rst), .checkReq(checkReq), .windowReq(windowReq),
   .flashAddr(flashAddr), .chipSelN(chipSelN), .outEnN(outEnN),
   .wrEnN(wrEnN), .data_lines_o(data_lines_o),
   .data_lines_oe(data_lines_oe), .busy(busy), .resultValid(resultValid),
   .result(result), .windowValid(windowValid));

//--- dv/fwsr_flash_model.sv
// Flash status side: mode stands in for the command sequences.
module fwsr_flash_model (
   input  wire logic        chipSelN, // Select.
   input  wire logic        outEnN,   // Read strobe.
   input  wire logic        wrEnN,    // Write strobe.
   input  wire logic [15:0] wrWord,   // Host word.
   input  wire logic        setMode,  // Load newMode.
   input  wire logic [1:0]  newMode,  // 0 read,1 erase,2 fail,3 suspend.
   input  wire logic        settle,   // Activity stops after two reads.
   output logic      [15:0] dataOut,  // Data lines.
   output logic             readyN    // Ready pin.
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [1:0]  mode = 2'h0;
   logic        act = 1'b0;
   logic        sect = 1'b0;
   logic [15:0] word;
   logic [15:0] last = 16'h0000;
   wire         rdN = chipSelN | outEnN;
   logic [1:0]  seenMode = 2'h0;
   logic [1:0]  nRd = 2'h0;
   wire         frozen = settle && mode == seenMode && nRd >= 2'h2;
   wire         runs = (mode == 2'h1 || mode == 2'h2) && !frozen;
   // Status is valid from the end of the command; reset word ends it.
   always @(posedge wrEnN or posedge setMode)
      if (setMode) mode <= newMode;
      else if (wrWord == 16'h00f0) mode <= 2'h0;
   // Each read start advances the toggle bits. With settle set, the
   // activity bit stops after two reads of a mode, as when the
   // operation ends just as the timeout bit rises.
   always @(negedge rdN) begin
      if (runs) act <= ~act;
      if (mode[0]) sect <= ~sect;
      if (mode != seenMode) nRd <= 2'h1;
      else if (nRd != 2'h3) nRd <= nRd + 2'h1;
      seenMode <= mode;
   end
   always_comb
      case (mode)
         2'h0: word = 16'h1234;
         2'h1: word = {8'h00, 1'b0, act, 2'b00, 1'b1, sect, 2'b00};
         2'h2: word = {8'h00, 1'b1, act, 1'b1, 5'h00};
         default: word = {8'h00, 1'b1, act, 3'b000, sect, 2'b00};
      endcase
   // Released lines show the inverse, so a stale sample cannot pass.
   always @(posedge rdN) last <= word;
   assign dataOut = rdN ? ~last : word;
   assign readyN = !(mode == 2'h1 || mode == 2'h2);
endmodule // fwsr_flash_model

//--- dv/tb_flash_write_status_reporting.sv
module tb_flash_write_status_reporting;
   import fwsr_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 1'b0, rst = 1'b1, checkReq = 1'b0, windowReq = 1'b0;
   logic setMode = 1'b0, chipSelN, outEnN, wrEnN, data_lines_oe, busy;
   logic resultValid, eraseActive, suspended, windowValid, windowClosed;
   logic readyLevel, readyN;
   logic [1:0]  newMode = 2'h0;
   logic [15:0] data_lines_o, flashOut;
   logic [21:0] flashAddr;
   logic [21:0] addr = 22'h000100;
   logic        settle = 1'b0;
   fwsr_result_t result;
   int n_mismatch = 0, n_tests = 0;
   wire [15:0] dataBus = data_lines_oe ? data_lines_o : flashOut;
   always #25 clk = ~clk;
   fwsr_status_poller i_dut (.clk(clk), .rst(rst), .checkReq(checkReq),
      .windowReq(windowReq), .statusAddr(addr),
      .data_lines_i(dataBus), .operation_done_pin_n(readyN),
      .flashAddr(flashAddr), .chipSelN(chipSelN), .outEnN(outEnN),
      .wrEnN(wrEnN), .data_lines_o(data_lines_o),
      .data_lines_oe(data_lines_oe), .busy(busy), .resultValid(resultValid),
      .result(result), .eraseActive(eraseActive), .suspended(suspended),
      .windowValid(windowValid), .windowClosed(windowClosed),
      .readyLevel(readyLevel));
   fwsr_flash_model i_flash (.chipSelN(chipSelN), .outEnN(outEnN),
      .wrEnN(wrEnN), .wrWord(data_lines_o), .setMode(setMode),
      .newMode(newMode), .settle(settle), .dataOut(flashOut),
      .readyN(readyN));
   ///////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      n_tests++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic end_sim;
      $display("Comparisons %0d, mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   // The bounded wait ends the run if no answer pulse comes.
   task automatic ask(input logic win);
      int i;
      @(negedge clk);
      checkReq = !win;
      windowReq = win;
      @(negedge clk);
      checkReq = 1'b0;
      windowReq = 1'b0;
      for (i = 0; i < 60 && !(resultValid || windowValid); i++) @(negedge clk);
      if (i == 60) begin
         n_mismatch++;
         end_sim;
      end
   endtask
   task automatic setOp(input logic [1:0] m);
      @(negedge clk);
      newMode = m;
      setMode = 1'b1;
      @(negedge clk);
      setMode = 1'b0;
   endtask
   ///////////////////////////////////////////////////////////////////////////
   task automatic scIdle;
      setOp(2'h0);
      ask(1'b0);
      check(16'(result), 16'(FWSR_DONE));
      check(16'(readyLevel), 16'h0001);
      check(16'(busy), 16'h0000);
      check(flashAddr[15:0], 16'h0100);
      ask(1'b1);
      check(16'(windowClosed), 16'h0000);
   endtask
   task automatic scErase;
      addr = 22'h002a00;
      setOp(2'h1);
      ask(1'b0);
      check(16'(result), 16'(FWSR_BUSY));
      check(16'({eraseActive, suspended, readyLevel}), 16'h0004);
      check(flashAddr[15:0], 16'h2a00);
      ask(1'b1);
      check(16'(windowClosed), 16'h0001);
      ask(1'b0);
      check(16'(result), 16'(FWSR_BUSY));
   endtask
   task automatic scFail;
      setOp(2'h2);
      ask(1'b0);
      check(16'(result), 16'(FWSR_FAILED));
      ask(1'b0);
      check(16'(result), 16'(FWSR_DONE));
      // Toggle stops as the timeout bit rises: the recheck must pass.
      settle = 1'b1;
      setOp(2'h2);
      ask(1'b0);
      check(16'(result), 16'(FWSR_DONE));
      settle = 1'b0;
   endtask
   task automatic scSuspend;
      setOp(2'h3);
      ask(1'b0);
      check(16'({eraseActive, suspended, readyLevel}), 16'h0007);
      check(16'(result), 16'(FWSR_DONE));
   endtask
   initial begin
      repeat (4) @(negedge clk);
      rst = 1'b0;
      scIdle;
      scErase;
      scFail;
      scSuspend;
      end_sim;
   end
endmodule // tb_flash_write_status_reporting
